// file: design/serial_port_pkg.sv
// Shared constants and register layouts for the four-mode serial port
package serial_port_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_SERIAL_BUFFER  = 8'h00;
  localparam logic [7:0] OFF_SERIAL_CONTROL = 8'h04;
  localparam logic [7:0] OFF_BAUD_CONFIG    = 8'h08;
  localparam logic [7:0] OFF_TIMER_MODE     = 8'h0c;
  localparam logic [7:0] OFF_TIMER1_HIGH    = 8'h10;
  localparam logic [7:0] OFF_TIMER2_CONTROL = 8'h14;
  localparam logic [7:0] OFF_RELOAD_PAIR    = 8'h18;
  localparam logic [7:0] OFF_TIMER2_COUNT   = 8'h1c;

  // Serial mode encodings of the mode field
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [1:0] MODE_VAR9 = 2'h3;

  // serial_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] mode;
    logic       multiprocFilter;
    logic       rxEnable;
    logic       txNinthBit;
    logic       rxNinthBit;
    logic       txDoneFlag;
    logic       rxDoneFlag;
  } serial_control_type;

  // timer2_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic overflowFlag;
    logic extFlag;
    logic rxClockSelect;
    logic txClockSelect;
    logic extEnable;
    logic run;
    logic counterSelect;
    logic spare;
  } timer2_control_type;

  // Baud configuration layout, bit 7 down to bit 0
  typedef struct packed {
    logic       baudDouble;
    logic       timer1Run;
    logic [5:0] spare;
  } baud_config_type;

  // Reset values
  localparam logic [7:0]  RST_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0]  RST_TIMER2_CONTROL = 8'h00;
  localparam logic [7:0]  RST_BAUD_CONFIG    = 8'h00;
  localparam logic [7:0]  RST_TIMER_MODE     = 8'h00;
  localparam logic [7:0]  RST_BYTE           = 8'h00;
  localparam logic [15:0] RST_WORD           = 16'h0000;

  // Timer 1 auto-reload timer selection in the upper nibble of timer_mode_reg
  localparam logic [3:0] T1_AUTO_RELOAD_NIBBLE = 4'h2;

  // Timing counts in CPU clocks, in sixteenths of a bit, or in bits per frame
  localparam int MODE0_DIV      = 6;
  localparam int MODE0_CLK_RISE = 2;
  localparam int T1_PRESCALE    = 12;
  localparam int TICKS_PER_BIT  = 16;
  localparam int SAMPLE_FIRST   = 7;
  localparam int SAMPLE_SECOND  = 8;
  localparam int SAMPLE_THIRD   = 9;
  localparam int BITS_MODE0     = 8;
  localparam int FRAME_MODE1    = 10;
  localparam int FRAME_MODE23   = 11;

  // Two-of-three vote over the receive samples
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

endpackage

// file: design/baud_tick_gen.sv
// Timer 1 and Timer 2 baud sources and the sixteen-times bit ticks
`timescale 1ns/10ps
module baud_tick_gen #(
  parameter int T1_PRESCALE = serial_port_pkg::T1_PRESCALE
) (
  input  wire logic                                mclk,
  input  wire logic                                nrst,
  input  wire serial_port_pkg::baud_config_type    baudCfg,
  input  wire logic                                timer1Enable,
  input  wire logic [7:0]                          timer1Reload,
  input  wire serial_port_pkg::timer2_control_type t2Ctl,
  input  wire logic [15:0]                         reloadPair,
  input  wire logic                                t2Load,
  input  wire logic [15:0]                         t2LoadValue,
  input  wire logic                                t2CountPin,
  input  wire logic                                t2ExtPin,
  output logic [15:0]                              t2Count,
  output logic                                     t2ExtEdge,
  output logic                                     txTick,
  output logic                                     rxTick,
  output logic                                     mode2Tick
);
  logic [3:0]  t1PreQ;
  logic [7:0]  t1CountQ;
  logic        t1OvfQ;
  logic        t1HalfQ;
  logic        t2OvfQ;
  logic        t2CntPrevQ;
  logic        t2ExtPrevQ;
  logic        m2HalfQ;
  logic        t1Tick;
  logic        t2Inc;

  // Timer 1 in 8-bit auto-reload, counting once per twelve CPU clocks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      t1PreQ   <= 4'h0;
      t1CountQ <= 8'h00;
      t1OvfQ   <= 1'b0;
    end else begin
      t1OvfQ <= 1'b0;
      if (timer1Enable) begin
        if (t1PreQ == 4'(T1_PRESCALE - 1)) begin
          t1PreQ <= 4'h0;
          if (t1CountQ == 8'hff) begin
            t1CountQ <= timer1Reload;
            t1OvfQ   <= 1'b1;
          end else begin
            t1CountQ <= t1CountQ + 8'h01;
          end
        end else begin
          t1PreQ <= t1PreQ + 4'h1;
        end
      end
    end
  end

  // Halving stages for the non-doubled rates
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      t1HalfQ <= 1'b0;
      m2HalfQ <= 1'b0;
    end else begin
      m2HalfQ <= ~m2HalfQ;
      if (t1OvfQ) begin
        t1HalfQ <= ~t1HalfQ;
      end
    end
  end

  assign t1Tick    = t1OvfQ & (baudCfg.baudDouble | t1HalfQ);
  assign mode2Tick = baudCfg.baudDouble | m2HalfQ;

  // Timer 2 counts clocks or falling pin edges while it is a baud source
  assign t2Inc = t2Ctl.run & (t2Ctl.rxClockSelect | t2Ctl.txClockSelect)
                 & (t2Ctl.counterSelect ? (t2CntPrevQ & ~t2CountPin) : 1'b1);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      t2Count    <= 16'h0000;
      t2OvfQ     <= 1'b0;
      t2CntPrevQ <= 1'b1;
      t2ExtPrevQ <= 1'b1;
    end else begin
      t2CntPrevQ <= t2CountPin;
      t2ExtPrevQ <= t2ExtPin;
      t2OvfQ     <= 1'b0;
      if (t2Load) begin
        t2Count <= t2LoadValue;
      end else if (t2Inc) begin
        if (t2Count == 16'hffff) begin
          t2Count <= reloadPair;
          t2OvfQ  <= 1'b1;
        end else begin
          t2Count <= t2Count + 16'h0001;
        end
      end
    end
  end

  // External falling edge only flags, it never reloads the count
  assign t2ExtEdge = t2Ctl.extEnable & t2ExtPrevQ & ~t2ExtPin;

  // Each direction picks Timer 2 or Timer 1 on its own
  assign txTick = t2Ctl.txClockSelect ? t2OvfQ : t1Tick;
  assign rxTick = t2Ctl.rxClockSelect ? t2OvfQ : t1Tick;

endmodule

// file: design/serial_port.sv
// Four-mode serial port with AHB-Lite register access
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - Transmit and receive run together in modes 1-3; a new receive may start before the buffer is read.
// - Buffer writes load the transmitter; buffer reads return the separate receive register.
// - Mode 0 shifts 8 bits LSB first on rx pin, clock on tx pin, CPU/6.
// - Mode 1 frame: start, 8 data LSB first, stop; stop stored in rx ninth bit.
// - Modes 2/3 frame: start, 8 data, ninth bit, stop; stop discarded on receive.
// - Mode 2 bit rate is CPU/32, or CPU/16 with baud_double set.
// - Mode 3 equals mode 2 except its rate comes from a timer.
// - Any buffer write starts a transmission in every mode.
// - Mode 0 receive starts on enable with flag clear; others on start bit.
// - Modes 2/3 with filter set deliver only frames whose ninth bit is one.
// - Filter ignored in mode 0; mode 1 with filter needs a valid stop bit.
// - Timer 1 rate: overflow rate over 32, doubled with baud_double.
// - Timer 1 auto-reload: count reloads from timer1_high_byte, prescaled by twelve.
// - Timer 2 clock selects make it the transmit and/or receive rate source.
// - Timer 2 rollover reloads from the reload pair; bit rate is overflow/16.
// - Timer 2 timer function counts every CPU clock in baud mode.
// - Timer 2 rollover in baud mode sets no overflow flag.
// - External falling edge sets t2_ext_flag without reloading the count.
// - Receiver samples at sixteenths 7, 8, 9 and takes the majority.
// - A start bit not sampled low sends the receiver back to idle.
// - After the last bit the transmitter idles the line and sets tx_done_flag.
module serial_port #(
  parameter int T1_PRESCALE = serial_port_pkg::T1_PRESCALE
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rxPinIn,
  output logic             rxPinOut,
  output logic             rxPinOeN,
  output logic             txPinOut,
  input  wire logic        t2CountPin,
  input  wire logic        t2ExtPin
);
  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SEND} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SHIFT0} rx_state_type;

  serial_port_pkg::serial_control_type serialControlQ;
  serial_port_pkg::timer2_control_type timer2ControlQ;
  serial_port_pkg::baud_config_type    baudConfigQ;
  logic [7:0]   timerModeQ;
  logic [7:0]   timer1HighQ;
  logic [15:0]  reloadPairQ;
  logic [7:0]   rxBufferQ;
  logic         wrPendQ;
  logic [7:0]   wrAddrQ;
  logic [31:0]  rdValue;
  logic         addrPhase;
  logic [15:0]  t2Count;
  logic         t2ExtEdge;
  logic         txTickT;
  logic         rxTickT;
  logic         mode2Tick;
  logic         txTick;
  logic         rxTick;
  logic         timer1Enable;
  logic         isMode0;
  tx_state_type txStateQ;
  rx_state_type rxStateQ;
  logic [10:0]  txShiftQ;
  logic [3:0]   txLeftQ;
  logic         txBitQ;
  logic         txM0Q;
  logic         txDoneSetQ;
  logic [3:0]   txDivQ;
  logic         txBoundary;
  logic [2:0]   m0CntQ;
  logic         m0Busy;
  logic         m0Mid;
  logic         m0End;
  logic         sclkQ;
  logic         rxPrevQ;
  logic [3:0]   rxDivQ;
  logic [3:0]   rxIdxQ;
  logic [9:0]   rxShiftQ;
  logic         s7Q;
  logic         s8Q;
  logic         rxVote;
  logic         rxLoadQ;
  logic [7:0]   rxDataQ;
  logic         rxNinthQ;

  // Write strobe for one register in the data phase
  function automatic logic wrHit(input logic pend, input logic [7:0] a, input logic [7:0] off);
    wrHit = pend & (a == off);
  endfunction

  assign isMode0   = serialControlQ.mode == serial_port_pkg::MODE_SHIFT;
  assign addrPhase = hsel & hready & htrans[1];
  assign timer1Enable = baudConfigQ.timer1Run & (timerModeQ[7:4] == serial_port_pkg::T1_AUTO_RELOAD_NIBBLE);

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    case (haddr[7:0])
      serial_port_pkg::OFF_SERIAL_BUFFER:  rdValue = {24'h000000, rxBufferQ};
      serial_port_pkg::OFF_SERIAL_CONTROL: rdValue = {24'h000000, serialControlQ};
      serial_port_pkg::OFF_BAUD_CONFIG:    rdValue = {24'h000000, baudConfigQ};
      serial_port_pkg::OFF_TIMER_MODE:     rdValue = {24'h000000, timerModeQ};
      serial_port_pkg::OFF_TIMER1_HIGH:    rdValue = {24'h000000, timer1HighQ};
      serial_port_pkg::OFF_TIMER2_CONTROL: rdValue = {24'h000000, timer2ControlQ};
      serial_port_pkg::OFF_RELOAD_PAIR:    rdValue = {16'h0000, reloadPairQ};
      serial_port_pkg::OFF_TIMER2_COUNT:   rdValue = {16'h0000, t2Count};
      default:                             rdValue = 32'h00000000;
    endcase
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wrPendQ   <= 1'b0;
      wrAddrQ   <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPendQ   <= addrPhase & hwrite;
      wrAddrQ   <= haddr[7:0];
      hrdata    <= (addrPhase & ~hwrite) ? rdValue : 32'h00000000;
    end
  end

  // Plain configuration registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      baudConfigQ <= serial_port_pkg::RST_BAUD_CONFIG;
      timerModeQ  <= serial_port_pkg::RST_TIMER_MODE;
      timer1HighQ <= serial_port_pkg::RST_BYTE;
      reloadPairQ <= serial_port_pkg::RST_WORD;
    end else begin
      if (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_BAUD_CONFIG)) baudConfigQ <= hwdata[7:0];
      if (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_TIMER_MODE)) timerModeQ <= hwdata[7:0];
      if (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_TIMER1_HIGH)) timer1HighQ <= hwdata[7:0];
      if (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_RELOAD_PAIR)) reloadPairQ <= hwdata[15:0];
    end
  end

  // Control and status; hardware sets win over a same-cycle software write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      serialControlQ <= serial_port_pkg::RST_SERIAL_CONTROL;
    end else begin
      if (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_SERIAL_CONTROL)) serialControlQ <= hwdata[7:0];
      if (txDoneSetQ) serialControlQ.txDoneFlag <= 1'b1;
      if (rxLoadQ) begin
        serialControlQ.rxDoneFlag <= 1'b1;
        serialControlQ.rxNinthBit <= rxNinthQ;
      end
    end
  end

  // Timer 2 control; the external edge flag is sticky
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer2ControlQ <= serial_port_pkg::RST_TIMER2_CONTROL;
    end else begin
      if (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_TIMER2_CONTROL)) timer2ControlQ <= hwdata[7:0];
      if (t2ExtEdge) timer2ControlQ.extFlag <= 1'b1;
    end
  end

  // Receive holding register, separate from the transmit shifter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxBufferQ <= serial_port_pkg::RST_BYTE;
    end else if (rxLoadQ) begin
      rxBufferQ <= rxDataQ;
    end
  end

  baud_tick_gen #(
    .T1_PRESCALE (T1_PRESCALE)
  ) baudGen (
    .mclk         (mclk),
    .nrst         (nrst),
    .baudCfg      (baudConfigQ),
    .timer1Enable (timer1Enable),
    .timer1Reload (timer1HighQ),
    .t2Ctl        (timer2ControlQ),
    .reloadPair   (reloadPairQ),
    .t2Load       (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_TIMER2_COUNT)),
    .t2LoadValue  (hwdata[15:0]),
    .t2CountPin   (t2CountPin),
    .t2ExtPin     (t2ExtPin),
    .t2Count      (t2Count),
    .t2ExtEdge    (t2ExtEdge),
    .txTick       (txTickT),
    .rxTick       (rxTickT),
    .mode2Tick    (mode2Tick)
  );

  // Mode 2 uses the fixed CPU divider, modes 1 and 3 the timers
  assign txTick = (serialControlQ.mode == serial_port_pkg::MODE_FIXED9) ? mode2Tick : txTickT;
  assign rxTick = (serialControlQ.mode == serial_port_pkg::MODE_FIXED9) ? mode2Tick : rxTickT;

  // Free-running transmit divide-by-16; bits align to its rollover
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txDivQ <= 4'h0;
    end else if (txTick) begin
      txDivQ <= txDivQ + 4'h1;
    end
  end
  assign txBoundary = txTick & (txDivQ == 4'(serial_port_pkg::TICKS_PER_BIT - 1));

  // Mode 0 bit timer, six clocks per bit
  assign m0Busy = (txM0Q & (txStateQ == TX_SEND)) | (rxStateQ == RX_SHIFT0);
  assign m0Mid  = m0Busy & (m0CntQ == 3'(serial_port_pkg::MODE0_CLK_RISE));
  assign m0End  = m0Busy & (m0CntQ == 3'(serial_port_pkg::MODE0_DIV - 1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      m0CntQ <= 3'h0;
      sclkQ  <= 1'b1;
    end else begin
      m0CntQ <= (m0Busy & ~m0End) ? m0CntQ + 3'h1 : 3'h0;
      // Low for counts one to three, so the first and last bits keep full phases
      sclkQ  <= ~m0Busy | (m0CntQ > 3'(serial_port_pkg::MODE0_CLK_RISE));
    end
  end

  // Transmitter, restarted by every buffer write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txStateQ   <= TX_IDLE;
      txShiftQ   <= 11'h7ff;
      txLeftQ    <= 4'h0;
      txBitQ     <= 1'b1;
      txM0Q      <= 1'b0;
      txDoneSetQ <= 1'b0;
    end else begin
      txDoneSetQ <= 1'b0;
      if (wrHit(wrPendQ, wrAddrQ, serial_port_pkg::OFF_SERIAL_BUFFER)) begin
        txM0Q <= isMode0;
        if (isMode0) begin
          txBitQ   <= hwdata[0];
          txShiftQ <= {4'hf, hwdata[7:1]};
          txLeftQ  <= 4'(serial_port_pkg::BITS_MODE0 - 1);
          txStateQ <= TX_SEND;
        end else if (serialControlQ.mode == serial_port_pkg::MODE_ASYNC8) begin
          txShiftQ <= {2'b11, hwdata[7:0], 1'b0};
          txLeftQ  <= 4'(serial_port_pkg::FRAME_MODE1 - 1);
          txStateQ <= TX_SYNC;
        end else begin
          txShiftQ <= {1'b1, serialControlQ.txNinthBit, hwdata[7:0], 1'b0};
          txLeftQ  <= 4'(serial_port_pkg::FRAME_MODE23 - 1);
          txStateQ <= TX_SYNC;
        end
      end else begin
        case (txStateQ)
          TX_IDLE: begin
            txBitQ <= 1'b1;
          end
          TX_SYNC: begin
            if (txBoundary) begin
              txBitQ   <= txShiftQ[0];
              txShiftQ <= {1'b1, txShiftQ[10:1]};
              txStateQ <= TX_SEND;
            end
          end
          TX_SEND: begin
            if (txM0Q ? m0End : txBoundary) begin
              if (txLeftQ == 4'h0) begin
                txBitQ     <= 1'b1;
                txStateQ   <= TX_IDLE;
                txDoneSetQ <= 1'b1;
              end else begin
                txBitQ   <= txShiftQ[0];
                txShiftQ <= {1'b1, txShiftQ[10:1]};
                txLeftQ  <= txLeftQ - 4'h1;
              end
            end
          end
          default: begin
            txStateQ <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // Pin drivers; the rx pin is driven only while mode 0 transmits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txPinOut <= 1'b1;
      rxPinOut <= 1'b1;
      rxPinOeN <= 1'b1;
    end else begin
      txPinOut <= isMode0 ? sclkQ : (txM0Q ? 1'b1 : txBitQ);
      rxPinOut <= txM0Q ? txBitQ : 1'b1;
      rxPinOeN <= ~(txM0Q & (txStateQ == TX_SEND));
    end
  end

  // Receive sample timing within each bit
  assign rxVote = serial_port_pkg::majority(s7Q, s8Q, rxPinIn);

  // Receiver
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxStateQ <= RX_IDLE;
      rxPrevQ  <= 1'b1;
      rxDivQ   <= 4'h0;
      rxIdxQ   <= 4'h0;
      rxShiftQ <= 10'h3ff;
      s7Q      <= 1'b1;
      s8Q      <= 1'b1;
      rxLoadQ  <= 1'b0;
      rxDataQ  <= 8'h00;
      rxNinthQ <= 1'b0;
    end else begin
      rxPrevQ <= rxPinIn;
      rxLoadQ <= 1'b0;
      case (rxStateQ)
        RX_IDLE: begin
          rxDivQ   <= 4'h0;
          rxIdxQ   <= 4'h0;
          rxShiftQ <= 10'h3ff;
          if (!isMode0 && serialControlQ.rxEnable && rxPrevQ && !rxPinIn) begin
            rxStateQ <= RX_ASYNC;
          end else if (isMode0 && serialControlQ.rxEnable && !serialControlQ.rxDoneFlag
                       && txStateQ == TX_IDLE) begin
            rxStateQ <= RX_SHIFT0;
          end
        end
        RX_ASYNC: begin
          if (rxTick) begin
            rxDivQ <= rxDivQ + 4'h1;
            if (rxDivQ == 4'(serial_port_pkg::SAMPLE_FIRST)) s7Q <= rxPinIn;
            if (rxDivQ == 4'(serial_port_pkg::SAMPLE_SECOND)) s8Q <= rxPinIn;
            if (rxDivQ == 4'(serial_port_pkg::SAMPLE_THIRD)) begin
              if (rxIdxQ == 4'h0 && rxVote) begin
                rxStateQ <= RX_IDLE;
              end else if (serialControlQ.mode == serial_port_pkg::MODE_ASYNC8
                           && rxIdxQ == 4'(serial_port_pkg::FRAME_MODE1 - 1)) begin
                rxStateQ <= RX_IDLE;
                rxDataQ  <= rxShiftQ[9:2];
                rxNinthQ <= rxVote;
                rxLoadQ  <= !serialControlQ.rxDoneFlag
                            && (!serialControlQ.multiprocFilter || rxVote);
              end else if (serialControlQ.mode != serial_port_pkg::MODE_ASYNC8
                           && rxIdxQ == 4'(serial_port_pkg::FRAME_MODE23 - 1)) begin
                rxStateQ <= RX_IDLE;
                rxDataQ  <= rxShiftQ[8:1];
                rxNinthQ <= rxShiftQ[9];
                rxLoadQ  <= !serialControlQ.rxDoneFlag
                            && (!serialControlQ.multiprocFilter || rxShiftQ[9]);
              end else begin
                rxShiftQ <= {rxVote, rxShiftQ[9:1]};
                rxIdxQ   <= rxIdxQ + 4'h1;
              end
            end
          end
        end
        RX_SHIFT0: begin
          if (m0Mid) rxShiftQ <= {rxPinIn, rxShiftQ[9:1]};
          if (m0End) begin
            if (rxIdxQ == 4'(serial_port_pkg::BITS_MODE0 - 1)) begin
              rxStateQ <= RX_IDLE;
              rxDataQ  <= rxShiftQ[9:2];
              rxNinthQ <= serialControlQ.rxNinthBit;
              rxLoadQ  <= 1'b1;
            end else begin
              rxIdxQ <= rxIdxQ + 4'h1;
            end
          end
        end
        default: begin
          rxStateQ <= RX_IDLE;
        end
      endcase
    end
  end

endmodule

// file: tb/serial_port_sva.sv
// Assertions on the serial port bus answers and pin timing
`timescale 1ns/10ps
module serial_port_sva (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rxPinOut,
  input wire logic        rxPinOeN,
  input wire logic        txPinOut
);
  logic rdPhase_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Marks the data phase of a read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rdPhase_q <= 1'b0;
    else rdPhase_q <= hsel && hready && htrans[1] && !hwrite;
  end
  ready_high_a: assert property (hreadyout) else $error("bus stalled");
  resp_okay_a: assert property (!hresp) else $error("error response");
  rdata_idle_a: assert property (!rdPhase_q |-> hrdata == 32'h0) else $error("stray read data");
  drive_idle_a: assert property (rxPinOeN |-> rxPinOut) else $error("released data not high");
  shift_low_a: assert property ($fell(txPinOut) && !rxPinOeN |-> !txPinOut[*3] ##1 txPinOut)
    else $error("shift clock low phase");
  shift_high_a: assert property ($rose(txPinOut) && !rxPinOeN |-> txPinOut[*3])
    else $error("shift clock high phase");
  shift_span_a: assert property ($fell(rxPinOeN) |-> !rxPinOeN[*8]) else $error("drive too short");
  line_low_a: assert property ($fell(txPinOut) |-> !txPinOut[*3]) else $error("line glitch");
  cover property ($fell(rxPinOeN));
  cover property (rdPhase_q && hrdata != 32'h0);
  cover property ($fell(txPinOut) && rxPinOeN);
endmodule
bind serial_port serial_port_sva chk (.mclk, .nrst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .rxPinOut, .rxPinOeN, .txPinOut);

// file: tb/serial_peer.sv
// Remote serial device: sends and captures 11-bit frames at 16 clocks a bit
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT = 16
) (
  input  wire logic        mclk,
  input  wire logic        txLine,
  input  wire logic [10:0] sendFrame,
  input  wire logic        sendReq,
  output logic             rxLine,
  output logic [10:0]      gotFrame
);
  initial rxLine = 1'b1;
  // Sends start, data LSB first, ninth and stop, then idles high
  always @(posedge sendReq) begin
    for (int i = 0; i < 11; i++) begin
      rxLine <= sendFrame[i];
      repeat (BIT) @(posedge mclk);
    end
    rxLine <= 1'b1;
  end
  // Captures an outgoing frame at mid-bit
  always @(negedge txLine) begin
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 11; i++) begin
      gotFrame[i] <= txLine;
      repeat (BIT) @(posedge mclk);
    end
  end
endmodule

// file: tb/serial_port_tb.sv
// Directed bench for the serial port against a remote serial peer
`timescale 1ns/10ps
module serial_port_tb;
  logic        mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, sendReq = 1'b0, t2Ext = 1'b1;
  logic [7:0]  m0Cap;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [10:0] sendFrame = 11'h7ff, gotFrame;
  logic        hreadyout, hresp, rxPinOut, rxPinOeN, txPinOut, peerRx;
  wire logic   rxPinIn = rxPinOeN ? peerRx : rxPinOut;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  serial_port #(.T1_PRESCALE(1)) DUT (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxPinIn, .rxPinOut, .rxPinOeN, .txPinOut,
    .t2CountPin(1'b1), .t2ExtPin(t2Ext));
  serial_peer peer (.mclk, .txLine(txPinOut), .sendFrame, .sendReq, .rxLine(peerRx), .gotFrame);
  // Mode 0 data taken at each rising shift clock while the port drives the data pin
  always @(posedge txPinOut) if (!rxPinOeN) m0Cap <= {rxPinOut, m0Cap[7:1]};
  // Clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask
  // Polls control until a flag sets, bounded
  task automatic waitSet(input logic [31:0] m);
    bus(1'b0, 8'h04, 32'h0);
    for (int i = 0; i < 300 && (rd & m) === 32'h0; i++) bus(1'b0, 8'h04, 32'h0);
  endtask
  task automatic sendF(input logic [10:0] f);
    @(posedge mclk);
    sendFrame <= f;
    sendReq <= 1'b1;
    @(posedge mclk);
    sendReq <= 1'b0;
  endtask
  task automatic resetRegs();
    rdChk(8'h04, 32'hffffffff, 32'h0, "control");
    bus(1'b1, 8'h20, 32'h5a);
    rdChk(8'h20, 32'hffffffff, 32'h0, "unmapped");
  endtask
  task automatic mode2Tx();
    bus(1'b1, 8'h08, 32'h80);
    bus(1'b1, 8'h04, 32'h88);
    bus(1'b1, 8'h00, 32'ha5);
    waitSet(32'h2);
    chk("txDone", 32'h2, rd & 32'h2);
    chk("txFrame", 32'h74a, {21'h0, gotFrame});
  endtask
  task automatic mode2Rx();
    bus(1'b1, 8'h04, 32'hb0);
    sendF({2'b10, 8'h3c, 1'b0});
    repeat (200) @(posedge mclk);
    rdChk(8'h04, 32'h1, 32'h0, "rxDropped");
    sendF({2'b11, 8'h5a, 1'b0});
    waitSet(32'h1);
    chk("rxNinth", 32'h4, rd & 32'h4);
    rdChk(8'h00, 32'hff, 32'h5a, "rxData");
    sendF({2'b11, 8'h11, 1'b0});
    repeat (200) @(posedge mclk);
    rdChk(8'h00, 32'hff, 32'h5a, "rxOverrun");
  endtask
  // Mode 1: Timer 2 paces transmit, Timer 1 receive; timers are loaded before they run
  task automatic timerRates();
    bus(1'b1, 8'h0c, 32'h20);
    bus(1'b1, 8'h10, 32'hff);
    bus(1'b1, 8'h08, 32'hc0);
    bus(1'b1, 8'h1c, 32'hffff);
    bus(1'b1, 8'h18, 32'hffff);
    bus(1'b1, 8'h14, 32'h1c);
    bus(1'b1, 8'h04, 32'h50);
    bus(1'b1, 8'h00, 32'h3c);
    waitSet(32'h2);
    chk("t2Frame", 32'h278, {22'h0, gotFrame[9:0]});
    repeat (100) @(posedge mclk);
    sendF({2'b11, 8'hc3, 1'b0});
    waitSet(32'h1);
    chk("stopBit", 32'h4, rd & 32'h4);
    rdChk(8'h00, 32'hff, 32'hc3, "t1Rx");
    t2Ext <= 1'b0;
    rdChk(8'h14, 32'hc0, 32'h40, "t2Flags");
  endtask
  task automatic mode0();
    bus(1'b1, 8'h04, 32'h00);
    bus(1'b1, 8'h00, 32'h96);
    waitSet(32'h2);
    chk("shiftTxDone", 32'h2, rd & 32'h2);
    chk("shiftTx", 32'h96, {24'h0, m0Cap});
    bus(1'b1, 8'h04, 32'h10);
    waitSet(32'h1);
    rdChk(8'h00, 32'hff, 32'hff, "shiftRx");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    resetRegs();
    mode2Tx();
    mode2Rx();
    timerRates();
    mode0();
    final_report();
  end
endmodule
